// ===== logic/i2cs_irq.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Sticky event status, mask and level interrupt
module i2cs_irq #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // Events and software access
  input  wire logic [W-1:0] evt,
  input  wire logic         stsWr,
  input  wire logic         maskWr,
  input  wire logic [W-1:0] wdata,
  input  wire logic         levelReq,
  // State
  output logic      [W-1:0] sts,
  output logic      [W-1:0] mask,
  output logic              irq
);
  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      sts <= '0;
    end else begin
      sts <= (sts & ~(stsWr ? wdata : '0)) | evt;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mask <= '0;
    end else if (maskWr) begin
      mask <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (|(sts & mask)) || levelReq;
    end
  end
endmodule
`default_nettype wire

// ===== logic/i2cs_line_if.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Sampled bus line events
interface i2cs_line_if;
  logic sclRise;
  logic sclFall;
  logic sdaLvl;
  logic start;
  logic stop;
  modport src (output sclRise, output sclFall, output sdaLvl, output start, output stop);
  modport dst (input sclRise, input sclFall, input sdaLvl, input start, input stop);
endinterface
`default_nettype wire

// ===== logic/i2cs_pkg.sv
`default_nettype none
// =====================================================================
// Shared constants
package i2cs_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int CTRL_W = 4;
  localparam int IRQ_W  = 4;

  // =====================================================================
  // Register byte addresses
  localparam logic [ADDR_W-1:0] REG_RX_DATA  = 32'hFFFF_0930;
  localparam logic [ADDR_W-1:0] REG_ALT_ID   = 32'hFFFF_0938;
  localparam logic [ADDR_W-1:0] REG_CTRL     = 32'hFFFF_0928;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 32'hFFFF_092C;
  localparam logic [ADDR_W-1:0] REG_OWN_ID   = 32'hFFFF_0950;
  localparam logic [ADDR_W-1:0] REG_IRQ_STS  = 32'hFFFF_0954;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 32'hFFFF_0958;

  // =====================================================================
  // Field positions
  localparam int CTRL_EN    = 0;
  localparam int CTRL_EARLY = 1;
  localparam int CTRL_TXIRQ = 2;
  localparam int CTRL_ALTEN = 3;
  localparam int STA_EARLY  = 0;
  localparam int STA_UFLOW  = 1;
  localparam int STA_TXREQ  = 2;
  localparam int STA_ALTHIT = 8;
  localparam int IRQ_TXREQ  = 0;
  localparam int IRQ_UFLOW  = 1;
  localparam int IRQ_EARLY  = 2;
  localparam int IRQ_ALTHIT = 3;

  // =====================================================================
  // Reset values and codes
  localparam logic [BYTE_W-1:0] RX_RST     = 8'h00;
  localparam logic [BYTE_W-1:0] ALT_RST    = 8'h00;
  localparam logic [CTRL_W-1:0] CTRL_RST   = 4'h0;
  localparam logic [6:0]        OWN_ID_RST = 7'h3A;
  localparam logic [6:0]        GC_ADDR    = 7'h00;
  localparam logic [BYTE_W-1:0] IDLE_BYTE  = 8'hFF;
  localparam logic [2:0]        BIT_LAST   = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b011,
    ST_DATA = 3'b010,
    ST_DACK = 3'b110,
    ST_SKIP = 3'b100
  } i2cs_state_t;
endpackage
`default_nettype wire

// ===== logic/i2cs_slave_status.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Early-tx off: read match sets tx request after the direction bit's SCL fall.
// - Early-tx on: read match sets tx request after the direction bit's SCL rise.
// - Tx request with its interrupt enable set raises the interrupt.
// - Read match with empty transmit FIFO sets underflow at direction bit rise.
// - Early-tx off: early status mirrors transmit FIFO empty.
// - Early-tx on: write match sets early status at direction bit rise.
// - Early-tx on: early status asserts once per transfer; a status read clears it.
// - Receive data register: 8 bits, read only, resets to zero.
// - Alternate ID register: 8 bits read/write, used when control bit 3 set.
// - Hardware general call second byte is compared against the alternate ID.
// - Hardware general call second byte is left in the receive register.
module i2cs_slave_status (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst,
  // Register port
  input  wire logic [i2cs_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [i2cs_pkg::DATA_W-1:0] regWdata,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [i2cs_pkg::DATA_W-1:0] regRdata,
  // Two-wire pins
  input  wire logic                        sclIn,
  input  wire logic                        sdaIn,
  output logic                             sdaOut,
  output logic                             sdaOeN,
  // Transmit FIFO side
  input  wire logic                        txEmpty,
  input  wire logic [i2cs_pkg::BYTE_W-1:0] txByte,
  output logic                             txPop,
  // Interrupt
  output logic                             irq
);
  import i2cs_pkg::*;

  // =====================================================================
  // Declarations
  i2cs_line_if line ();

  i2cs_state_t              state;
  logic [2:0]               bitCnt;
  logic                     ackPhase;
  logic [BYTE_W-1:0]        shiftIn;
  logic [BYTE_W-1:0]        txShift;
  logic                     matched;
  logic                     dirRead;
  logic                     gcFirst;
  logic                     masterNack;
  logic [CTRL_W-1:0]        ctrl;
  logic [6:0]               ownId;
  logic [BYTE_W-1:0]        altId;
  logic [BYTE_W-1:0]        rxData;
  logic                     txReq;
  logic                     uflow;
  logic                     early;
  logic                     earlyDone;
  logic                     altHit;
  logic [IRQ_W-1:0]         irqEvt;
  logic [IRQ_W-1:0]         irqSts;
  logic [IRQ_W-1:0]         irqMask;
  logic [DATA_W-1:0]        statusWord;
  logic [BYTE_W-1:0]        txNext;

  logic earlyEn;
  logic lastBit;
  logic readNow;
  logic hitNow;
  logic dirRise;
  logic inAck;
  logic ackFall1;
  logic ackFall2;
  logic byteEndW;
  logic gcByteEnd;
  logic stsRead;
  logic txReqSet;
  logic uflowSet;
  logic earlySet;
  logic altHitSet;
  logic loadTx;

  i2cs_sync uSync (
    .mclk  (mclk),
    .rst   (rst),
    .sclIn (sclIn),
    .sdaIn (sdaIn),
    .line  (line.src)
  );

  // =====================================================================
  // Decode of bus phases
  assign earlyEn   = ctrl[CTRL_EARLY];
  assign lastBit   = (bitCnt == BIT_LAST);
  assign readNow   = line.sdaLvl;
  // General call is only a write; a read to address zero is not ours
  assign hitNow    = ctrl[CTRL_EN] && ((shiftIn[6:0] == ownId) ||
                     ((shiftIn[6:0] == GC_ADDR) && !readNow));
  assign dirRise   = line.sclRise && (state == ST_ADDR) && lastBit;
  assign inAck     = (state == ST_AACK) || (state == ST_DACK);
  assign ackFall1  = line.sclFall && inAck && !ackPhase;
  assign ackFall2  = line.sclFall && inAck && ackPhase;
  assign byteEndW  = ackFall1 && (state == ST_DACK) && !dirRead;
  assign gcByteEnd = byteEndW && gcFirst;
  assign stsRead   = regRd && (regAddr == REG_STATUS);
  assign txReqSet  = (ackFall1 && (state == ST_AACK) && matched && dirRead && !earlyEn) ||
                     (dirRise && hitNow && readNow && earlyEn);
  assign uflowSet  = dirRise && hitNow && readNow && txEmpty;
  assign earlySet  = dirRise && hitNow && !readNow && earlyEn && !earlyDone;
  assign altHitSet = gcByteEnd && ctrl[CTRL_ALTEN] && (shiftIn == altId);
  assign loadTx    = ackFall2 && matched && dirRead &&
                     !((state == ST_DACK) && masterNack);
  // An empty FIFO sends all ones, which leaves the line released
  assign txNext    = txEmpty ? IDLE_BYTE : txByte;

  // =====================================================================
  // Frame state machine
  always_ff @(posedge mclk) begin
    if (rst) begin
      state      <= ST_IDLE;
      bitCnt     <= '0;
      ackPhase   <= 1'b0;
      shiftIn    <= '0;
      matched    <= 1'b0;
      dirRead    <= 1'b0;
      gcFirst    <= 1'b0;
      masterNack <= 1'b0;
    end else if (line.stop) begin
      state    <= ST_IDLE;
      ackPhase <= 1'b0;
      matched  <= 1'b0;
      gcFirst  <= 1'b0;
    end else if (line.start) begin
      state    <= ST_ADDR;
      bitCnt   <= '0;
      ackPhase <= 1'b0;
      matched  <= 1'b0;
      gcFirst  <= 1'b0;
    end else begin
      case (state)
        ST_ADDR: begin
          if (line.sclRise) begin
            shiftIn <= {shiftIn[6:0], line.sdaLvl};
            bitCnt  <= bitCnt + 3'h1;
            if (lastBit) begin
              state   <= ST_AACK;
              matched <= hitNow;
              dirRead <= readNow;
              gcFirst <= hitNow && (shiftIn[6:0] == GC_ADDR) && !readNow;
            end
          end
        end
        ST_AACK: begin
          if (line.sclFall) begin
            if (!ackPhase) begin
              ackPhase <= 1'b1;
            end else begin
              ackPhase <= 1'b0;
              bitCnt   <= '0;
              state    <= matched ? ST_DATA : ST_SKIP;
            end
          end
        end
        ST_DATA: begin
          if (line.sclRise) begin
            shiftIn <= {shiftIn[6:0], line.sdaLvl};
            bitCnt  <= bitCnt + 3'h1;
            if (lastBit) begin
              state <= ST_DACK;
            end
          end
        end
        ST_DACK: begin
          if (line.sclRise && ackPhase) begin
            masterNack <= line.sdaLvl;
          end
          if (line.sclFall) begin
            if (!ackPhase) begin
              ackPhase <= 1'b1;
            end else begin
              ackPhase <= 1'b0;
              bitCnt   <= '0;
              gcFirst  <= 1'b0;
              state    <= (dirRead && masterNack) ? ST_SKIP : ST_DATA;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // =====================================================================
  // Data line drive, open drain: only ever pulls low
  always_ff @(posedge mclk) begin
    if (rst) begin
      sdaOeN  <= 1'b1;
      sdaOut  <= 1'b0;
      txShift <= '0;
      txPop   <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
      txPop  <= 1'b0;
      if (line.start || line.stop) begin
        sdaOeN <= 1'b1;
      end else if (ackFall1 && (state == ST_AACK)) begin
        sdaOeN <= !matched;
      end else if (ackFall1) begin
        sdaOeN <= dirRead;
      end else if (loadTx) begin
        sdaOeN  <= txNext[7];
        txShift <= {txNext[6:0], 1'b0};
        txPop   <= !txEmpty;
      end else if (ackFall2) begin
        sdaOeN <= 1'b1;
      end else if (line.sclFall && (state == ST_DATA) && dirRead && matched) begin
        sdaOeN  <= txShift[7];
        txShift <= {txShift[6:0], 1'b0};
      end
    end
  end

  // =====================================================================
  // Status flags
  always_ff @(posedge mclk) begin
    if (rst) begin
      txReq <= 1'b0;
    end else if (txReqSet) begin
      txReq <= 1'b1;
    end else if (line.start || line.stop || txPop) begin
      txReq <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      uflow <= 1'b0;
    end else if (uflowSet) begin
      uflow <= 1'b1;
    end else if (line.start || line.stop) begin
      uflow <= 1'b0;
    end
  end

  // A status read in the same cycle as a set loses, so no event is dropped
  always_ff @(posedge mclk) begin
    if (rst) begin
      early <= 1'b0;
    end else if (!earlyEn) begin
      early <= txEmpty;
    end else if (earlySet) begin
      early <= 1'b1;
    end else if (stsRead) begin
      early <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      earlyDone <= 1'b0;
    end else if (earlySet) begin
      earlyDone <= 1'b1;
    end else if (line.start || line.stop) begin
      earlyDone <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      altHit <= 1'b0;
    end else if (altHitSet) begin
      altHit <= 1'b1;
    end else if (line.start) begin
      altHit <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rxData <= RX_RST;
    end else if (byteEndW) begin
      rxData <= shiftIn;
    end
  end

  // =====================================================================
  // Register writes
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl  <= CTRL_RST;
      ownId <= OWN_ID_RST;
      altId <= ALT_RST;
    end else if (regWr && (regAddr == REG_CTRL)) begin
      ctrl <= regWdata[CTRL_W-1:0];
    end else if (regWr && (regAddr == REG_OWN_ID)) begin
      ownId <= regWdata[6:0];
    end else if (regWr && (regAddr == REG_ALT_ID)) begin
      altId <= regWdata[BYTE_W-1:0];
    end
  end

  // =====================================================================
  // Register reads, data valid the cycle after the strobe only
  always_comb begin
    statusWord             = '0;
    statusWord[STA_EARLY]  = early;
    statusWord[STA_UFLOW]  = uflow;
    statusWord[STA_TXREQ]  = txReq;
    statusWord[STA_ALTHIT] = altHit;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      regRdata <= '0;
    end else if (!regRd) begin
      regRdata <= '0;
    end else if (regAddr == REG_RX_DATA) begin
      regRdata <= {{(DATA_W-BYTE_W){1'b0}}, rxData};
    end else if (regAddr == REG_ALT_ID) begin
      regRdata <= {{(DATA_W-BYTE_W){1'b0}}, altId};
    end else if (regAddr == REG_CTRL) begin
      regRdata <= {{(DATA_W-CTRL_W){1'b0}}, ctrl};
    end else if (regAddr == REG_STATUS) begin
      regRdata <= statusWord;
    end else if (regAddr == REG_OWN_ID) begin
      regRdata <= {{(DATA_W-7){1'b0}}, ownId};
    end else if (regAddr == REG_IRQ_STS) begin
      regRdata <= {{(DATA_W-IRQ_W){1'b0}}, irqSts};
    end else if (regAddr == REG_IRQ_MASK) begin
      regRdata <= {{(DATA_W-IRQ_W){1'b0}}, irqMask};
    end else begin
      regRdata <= '0;
    end
  end

  // =====================================================================
  // Interrupts
  always_comb begin
    irqEvt             = '0;
    irqEvt[IRQ_TXREQ]  = txReqSet;
    irqEvt[IRQ_UFLOW]  = uflowSet;
    irqEvt[IRQ_EARLY]  = earlySet;
    irqEvt[IRQ_ALTHIT] = altHitSet;
  end

  i2cs_irq #(
    .W (IRQ_W)
  ) uIrq (
    .mclk     (mclk),
    .rst      (rst),
    .evt      (irqEvt),
    .stsWr    (regWr && (regAddr == REG_IRQ_STS)),
    .maskWr   (regWr && (regAddr == REG_IRQ_MASK)),
    .wdata    (regWdata[IRQ_W-1:0]),
    .levelReq (txReq && ctrl[CTRL_TXIRQ]),
    .sts      (irqSts),
    .mask     (irqMask),
    .irq      (irq)
  );

  // =====================================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence readHitLate;
    ackFall1 && (state == ST_AACK) && matched && dirRead && !earlyEn;
  endsequence
  sequence readHitEarly;
    dirRise && hitNow && readNow && earlyEn;
  endsequence
  sequence earlyArmed;
    earlyEn && earlyDone && !line.start && !line.stop ##1 earlyEn;
  endsequence
  sequence gcSecondByte;
    gcByteEnd;
  endsequence

  txreq_fall_a: assert property (readHitLate |=> txReq)
    else $error("tx request missing after direction bit fall");
  txreq_rise_a: assert property (readHitEarly |=> txReq)
    else $error("tx request missing after direction bit rise");
  txreq_irq_a: assert property (txReq && ctrl[CTRL_TXIRQ] |=> irq)
    else $error("interrupt not raised for tx request");
  uflow_set_a: assert property (uflowSet |=> uflow ##1 (uflow || $past(line.start || line.stop)))
    else $error("underflow flag not set or lost");
  early_mirror_a: assert property (!earlyEn |=> early == $past(txEmpty))
    else $error("early status does not follow fifo empty");
  early_set_a: assert property (earlySet |=> early && earlyDone)
    else $error("early status not set on write match");
  early_once_a: assert property (earlyArmed |-> !$rose(early))
    else $error("early status asserted twice in a transfer");
  early_clear_a: assert property (earlyEn && stsRead && !earlySet |=> !early)
    else $error("early status not cleared by status read");
  rx_readonly_a: assert property (regWr && !byteEndW |=> $stable(rxData))
    else $error("receive data changed without a received byte");
  alt_match_a: assert property (gcSecondByte and ctrl[CTRL_ALTEN] && shiftIn == altId |=> altHit)
    else $error("alternate id match not flagged");
  alt_gated_a: assert property (!ctrl[CTRL_ALTEN] |-> !altHitSet)
    else $error("alternate id used while disabled");
  gc_keep_a: assert property (gcSecondByte |=> rxData == $past(shiftIn))
    else $error("general call second byte not kept");
endmodule
`default_nettype wire

// ===== logic/i2cs_sync.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Pin synchroniser and edge finder
module i2cs_sync (
  // Clock and reset
  input  wire logic  mclk,
  input  wire logic  rst,
  // Pins
  input  wire logic  sclIn,
  input  wire logic  sdaIn,
  // Events
  i2cs_line_if.src   line
);
  logic sclMeta;
  logic sclSync;
  logic sclPrev;
  logic sdaMeta;
  logic sdaSync;
  logic sdaPrev;

  // Idle bus is high, so reset to high avoids a false start
  always_ff @(posedge mclk) begin
    if (rst) begin
      sclMeta <= 1'b1;
      sclSync <= 1'b1;
      sclPrev <= 1'b1;
      sdaMeta <= 1'b1;
      sdaSync <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclMeta <= sclIn;
      sclSync <= sclMeta;
      sclPrev <= sclSync;
      sdaMeta <= sdaIn;
      sdaSync <= sdaMeta;
      sdaPrev <= sdaSync;
    end
  end

  assign line.sclRise = sclSync && !sclPrev;
  assign line.sclFall = !sclSync && sclPrev;
  assign line.sdaLvl  = sdaSync;
  assign line.start   = sclSync && sclPrev && sdaPrev && !sdaSync;
  assign line.stop    = sclSync && sclPrev && !sdaPrev && sdaSync;
endmodule
`default_nettype wire

// ===== verification/i2cs_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Two-wire bus master model; SCL stands high between frames
module i2cs_master_model (
  // Open-drain lines, 1 = released
  output logic      scl,
  output logic      sdaDrv,
  // Resolved data line
  input  wire logic sdaLine
);
  // Quarter of a 125 ns bit period
  localparam realtime Q = 31.25;

  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end

  // =====================================================================
  // Bus conditions, also usable as a repeated start
  task automatic start();
    sdaDrv = 1'b1;
    #Q scl = 1'b1;
    #Q sdaDrv = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask

  task automatic stop();
    sdaDrv = 1'b0;
    #Q scl = 1'b1;
    #Q sdaDrv = 1'b1;
    #(2 * Q);
  endtask

  // =====================================================================
  // Bit halves; data only changes while SCL is low
  task automatic rise(input logic b);
    sdaDrv = b;
    #Q scl = 1'b1;
    #Q;
  endtask

  task automatic fall();
    #Q scl = 1'b0;
    #Q;
  endtask

  task automatic wrByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      rise(b[i]);
      fall();
    end
    rise(1'b1);
    ack = sdaLine;
    fall();
  endtask

  // Released data line lets the slave drive; nack ends the read
  task automatic rdByte(input logic nack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      rise(1'b1);
      b[i] = sdaLine;
      fall();
    end
    rise(nack);
    fall();
  endtask
endmodule
`default_nettype wire

// ===== verification/test_i2cs_slave_status.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Register and bus level test
module test_i2cs_slave_status;
  import i2cs_pkg::*;
  logic              mclk, rst, regWr, regRd, txEmpty, txPop, irq;
  logic              sdaOut, sdaOeN, mScl, mSda, ack;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata, regRdata;
  logic [BYTE_W-1:0] txByte, rxb;
  wire  logic        sdaW;
  int                n_mismatch, tests_run, cyc, pops;

  // Open drain: the pull-up wins unless a party pulls low
  assign sdaW = mSda & (sdaOeN | sdaOut);

  i2cs_slave_status u_dut (
    .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sclIn(mScl),
    .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .txEmpty(txEmpty),
    .txByte(txByte), .txPop(txPop), .irq(irq)
  );

  i2cs_master_model u_mst (.scl(mScl), .sdaDrv(mSda), .sdaLine(sdaW));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // =====================================================================
  // Checking and register access
  task automatic final_report();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdm(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m, e);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 chk(regRdata & m, e);
  endtask

  // Edge detection lags the pin by a few cycles
  task automatic settle();
    repeat (4) @(posedge mclk);
  endtask

  task automatic irqIs(input logic e);
    repeat (2) @(posedge mclk);
    #1 chk({15'h0, irq}, {15'h0, e});
  endtask

  task automatic addr7(input logic [6:0] a);
    u_mst.start();
    for (int i = 6; i >= 0; i--) begin
      u_mst.rise(a[i]);
      u_mst.fall();
    end
  endtask

  task automatic ackBit();
    u_mst.rise(1'b1);
    chk({15'h0, sdaW}, 16'h0000);
    chk({15'h0, sdaOut}, 16'h0000);
    u_mst.fall();
  endtask

  // Timeout ceiling well above the fewer than two thousand cycles the run needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (txPop === 1'b1) begin
      pops <= pops + 1;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  // =====================================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = '0;
    regWdata = '0;
    txEmpty = 1'b1;
    txByte = 8'h00;
    cyc = 0;
    pops = 0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rdm(REG_RX_DATA, 16'hFFFF, 16'h0000);
    rdm(REG_ALT_ID, 16'hFFFF, 16'h0000);
    wr(REG_ALT_ID, 16'h00A5);
    rdm(REG_ALT_ID, 16'hFFFF, 16'h00A5);
    wr(REG_RX_DATA, 16'h0012);
    rdm(REG_RX_DATA, 16'hFFFF, 16'h0000);
    rdm(32'hFFFF_0900, 16'hFFFF, 16'h0000);
    wr(REG_CTRL, 16'h0001);
    rdm(REG_STATUS, 16'h0001, 16'h0001);
    txEmpty <= 1'b0;
    rdm(REG_STATUS, 16'h0001, 16'h0000);
    txEmpty <= 1'b1;
    // Read with early transmit off and an empty FIFO
    addr7(OWN_ID_RST);
    u_mst.rise(1'b1);
    settle();
    rdm(REG_STATUS, 16'h0006, 16'h0002);
    u_mst.fall();
    settle();
    rdm(REG_STATUS, 16'h0004, 16'h0004);
    irqIs(1'b0);
    wr(REG_IRQ_MASK, 16'h0001);
    irqIs(1'b1);
    wr(REG_IRQ_STS, 16'h0001);
    irqIs(1'b0);
    wr(REG_CTRL, 16'h0005);
    irqIs(1'b1);
    ackBit();
    u_mst.rdByte(1'b1, rxb);
    chk({8'h00, rxb}, {8'h00, IDLE_BYTE});
    u_mst.stop();
    rdm(REG_STATUS, 16'h0006, 16'h0000);
    wr(REG_IRQ_MASK, 16'h0000);
    irqIs(1'b0);
    // Write with early transmit on
    wr(REG_CTRL, 16'h0003);
    // Clear the copy left over from mirror mode so the set below is real
    rdm(REG_STATUS, 16'h0000, 16'h0000);
    rdm(REG_STATUS, 16'h0001, 16'h0000);
    addr7(OWN_ID_RST);
    u_mst.rise(1'b0);
    settle();
    rdm(REG_STATUS, 16'h0001, 16'h0001);
    rdm(REG_STATUS, 16'h0001, 16'h0000);
    u_mst.fall();
    ackBit();
    u_mst.wrByte(8'h5A, ack);
    chk({15'h0, ack}, 16'h0000);
    rdm(REG_RX_DATA, 16'hFFFF, 16'h005A);
    rdm(REG_STATUS, 16'h0001, 16'h0000);
    u_mst.stop();
    // Read with early transmit on and a byte waiting
    txEmpty <= 1'b0;
    txByte <= 8'hC3;
    addr7(OWN_ID_RST);
    u_mst.rise(1'b1);
    settle();
    rdm(REG_STATUS, 16'h0006, 16'h0004);
    u_mst.fall();
    ackBit();
    u_mst.rdByte(1'b1, rxb);
    chk({8'h00, rxb}, 16'h00C3);
    chk(pops[15:0], 16'h0001);
    u_mst.stop();
    txEmpty <= 1'b1;
    // Hardware general call against the alternate ID
    wr(REG_CTRL, 16'h0009);
    u_mst.start();
    u_mst.wrByte({GC_ADDR, 1'b0}, ack);
    chk({15'h0, ack}, 16'h0000);
    u_mst.wrByte(8'hA5, ack);
    rdm(REG_STATUS, 16'h0100, 16'h0100);
    rdm(REG_RX_DATA, 16'hFFFF, 16'h00A5);
    u_mst.stop();
    final_report();
  end
endmodule
`default_nettype wire
